// ---- flash_host_pkg.sv ----
`default_nettype none
package flash_host_pkg;
  // ************************************************************
  // bus widths and bit positions
  // ************************************************************
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SECTOR_LSB = 11;
  localparam int unsigned BLOCK_LSB = 15;
  localparam int unsigned LOCK_BIT = 3;
  // ************************************************************
  // command addresses and codes
  // ************************************************************
  localparam logic [19:0] ADDR_UNLOCK1 = 20'h05555;
  localparam logic [19:0] ADDR_UNLOCK2 = 20'h02aaa;
  localparam logic [19:0] ADDR_GEN_QUERY = 20'h00055;
  localparam logic [19:0] ADDR_MAKER_ID = 20'h00000;
  localparam logic [19:0] ADDR_DEVICE_ID = 20'h00001;
  localparam logic [19:0] ADDR_LOCK_STATE = 20'h000ff;
  localparam logic [19:0] ADDR_SEC_USER_LO = 20'h00008;
  localparam logic [19:0] ADDR_SEC_USER_HI = 20'h0000f;
  localparam logic [15:0] DATA_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_QUERY = 16'h0098;
  localparam logic [15:0] CMD_ID_ENTRY = 16'h0090;
  localparam logic [15:0] CMD_SEC_ENTRY = 16'h0088;
  localparam logic [15:0] CMD_EXIT = 16'h00f0;
  localparam logic [15:0] CMD_SEC_PROG = 16'h00a5;
  localparam logic [15:0] CMD_SEC_LOCK = 16'h0085;
  localparam logic [15:0] DATA_LOCK_WORD = 16'h0000;
  // ************************************************************
  // pin timing, whole cycles at 125 MHz
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_STROBE_NS = 40;
  localparam int unsigned T_READ_NS = 70;
  localparam int unsigned T_RECOVER_NS = 30;
  localparam int unsigned T_RESET_NS = 500;
  localparam int unsigned STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_CYC = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ************************************************************
  // host operations and flash modes
  // ************************************************************
  typedef enum logic [3:0] {
    OP_READ,
    OP_WRITE,
    OP_QUERY_UNLOCKED,
    OP_QUERY_GENERAL,
    OP_ID_ENTRY,
    OP_SEC_ENTRY,
    OP_EXIT_LONG,
    OP_EXIT_SHORT,
    OP_SEC_PROGRAM,
    OP_SEC_LOCK,
    OP_RESET
  } op_t;
  typedef enum logic [2:0] {
    MODE_ARRAY,
    MODE_QUERY,
    MODE_ID,
    MODE_SEC
  } mode_t;
endpackage
`default_nettype wire

// ---- bus_cycle_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface bus_cycle_if;
  logic start;
  logic is_write;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic busy;
  logic done;
  logic [15:0] rdata;
  modport master (output start, output is_write, output addr, output wdata, input busy, input done, input rdata);
  modport engine (input start, input is_write, input addr, input wdata, output busy, output done, output rdata);
endinterface
`default_nettype wire

// ---- flash_bus_cycle.sv ----
`timescale 1ns/1ps
`default_nettype none
// one strobed read or write cycle on the flash pins
module flash_bus_cycle (
  input wire logic clk_in,
  input wire logic rst_n_in,
  bus_cycle_if.engine cyc,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic [19:0] addr_out,
  output logic [15:0] dq_out,
  output logic dq_oe_out,
  input wire logic [15:0] dq_in
);
  typedef enum logic [1:0] {C_IDLE, C_STROBE, C_RECOVER} cyc_state_t;
  localparam int unsigned STRB_R = flash_host_pkg::READ_CYC;
  localparam int unsigned STRB_W = flash_host_pkg::STROBE_CYC;
  localparam int unsigned RECOV = flash_host_pkg::RECOVER_CYC;
  cyc_state_t state_ff;
  logic [7:0] cnt_ff;
  logic wr_ff;
  logic done_ff;
  logic [15:0] rdata_ff;
  wire strobe_end = (state_ff == C_STROBE) && (cnt_ff == 8'h00);
  wire recov_end = (state_ff == C_RECOVER) && (cnt_ff == 8'h00);
  assign cyc.busy = (state_ff != C_IDLE);
  assign cyc.done = done_ff;
  assign cyc.rdata = rdata_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= C_IDLE;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      ce_n_out <= 1'b1;
      oe_n_out <= 1'b1;
      we_n_out <= 1'b1;
      addr_out <= 20'h00000;
      dq_out <= 16'h0000;
      dq_oe_out <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        C_IDLE: begin
          if (cyc.start) begin
            // write: ce low, we low, oe high; read: ce low, oe low, we high
            state_ff <= C_STROBE;
            wr_ff <= cyc.is_write;
            addr_out <= cyc.addr;
            dq_out <= cyc.wdata;
            dq_oe_out <= cyc.is_write;
            ce_n_out <= 1'b0;
            oe_n_out <= cyc.is_write;
            we_n_out <= !cyc.is_write;
            cnt_ff <= cyc.is_write ? 8'(STRB_W - 1) : 8'(STRB_R - 1);
          end
        end
        C_STROBE: begin
          if (strobe_end) begin
            // device latches data at we rising; dq released next phase
            state_ff <= C_RECOVER;
            if (!wr_ff) begin
              rdata_ff <= dq_in;
            end
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
            cnt_ff <= 8'(RECOV - 1);
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        C_RECOVER: begin
          dq_oe_out <= 1'b0;
          if (recov_end) begin
            state_ff <= C_IDLE;
            done_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: state_ff <= C_IDLE;
      endcase
    end
  end

  write_strobe_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !we_n_out |-> (!ce_n_out && oe_n_out && dq_oe_out)) else $error("write strobe without ce low oe high");
  read_strobe_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !oe_n_out |-> (!ce_n_out && we_n_out && !dq_oe_out)) else $error("read strobe with we or drive");
  data_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(we_n_out) |-> dq_oe_out) else $error("data dropped before we rise");
endmodule
`default_nettype wire

// ---- flash_id_query_modes.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// - query entry: unlock pair then 98H written at 5555H
// - general query entry: one write of 98H at 55H
// - query mode persists until the exit command is written, the reset pin is pulsed or another mode is entered
// - user half programmed by dedicated command, completion by toggle bits only; the host polls no toggle bit and answers once the fourth write ends
// - after lock-out the user half refuses programming
// - security read entry: unlock pair then 88H at 5555H, exit leaves
// - write: ce low we low oe high; read: ce low oe low we high
module flash_id_query_modes #(
  parameter int unsigned ADDR_W = flash_host_pkg::ADDR_W,
  parameter int unsigned DATA_W = flash_host_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire flash_host_pkg::op_t req_op_in,
  input wire logic [19:0] req_addr_in,
  input wire logic [15:0] req_data_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic rsp_refused_out,
  output flash_host_pkg::mode_t mode_out,
  output logic user_locked_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic rst_pin_n_out,
  output logic wp_n_out,
  input wire logic protect_boot_in,
  output logic [19:0] addr_out,
  output logic [15:0] dq_out,
  output logic dq_oe_out,
  input wire logic [15:0] dq_in
);
  // pin logic is fixed at 20 address and 16 data bits
  if (ADDR_W != 20 || DATA_W != 16) begin : g_width_check
    $error("flash_id_query_modes serves a 20-bit address and 16-bit data only");
  end
  // ************************************************************
  // sequencer state
  // ************************************************************
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_RESET, S_DONE} seq_state_t;
  seq_state_t state_ff;
  flash_host_pkg::op_t op_ff;
  flash_host_pkg::mode_t mode_ff;
  logic [19:0] addr_ff;
  logic [15:0] data_ff;
  logic [1:0] step_ff;
  logic [1:0] last_ff;
  logic [15:0] rdata_ff;
  logic rsp_ff;
  logic refused_ff;
  logic locked_ff;
  logic [7:0] rst_cnt_ff;
  logic start_ff;
  bus_cycle_if cyc();

  // step counts: three-write unlocked forms end at step 2, single writes at step 0
  wire is_unlocked_op = (req_op_in == flash_host_pkg::OP_QUERY_UNLOCKED) ||
                        (req_op_in == flash_host_pkg::OP_ID_ENTRY) ||
                        (req_op_in == flash_host_pkg::OP_SEC_ENTRY) ||
                        (req_op_in == flash_host_pkg::OP_EXIT_LONG);
  wire is_four_op = (req_op_in == flash_host_pkg::OP_SEC_PROGRAM) ||
                    (req_op_in == flash_host_pkg::OP_SEC_LOCK);
  wire [1:0] last_step = is_four_op ? 2'd3 : (is_unlocked_op ? 2'd2 : 2'd0);
  // user half words 8..f only, and only while unlocked
  wire sec_addr_ok = (req_addr_in >= flash_host_pkg::ADDR_SEC_USER_LO) &&
                     (req_addr_in <= flash_host_pkg::ADDR_SEC_USER_HI);
  wire refuse = (req_op_in == flash_host_pkg::OP_SEC_PROGRAM) && (locked_ff || !sec_addr_ok);
  wire accept = req_valid_in && (state_ff == S_IDLE);

  logic [19:0] cur_addr;
  logic [15:0] cur_data;
  logic cur_write;
  always_comb begin
    cur_addr = flash_host_pkg::ADDR_UNLOCK1;
    cur_data = flash_host_pkg::DATA_UNLOCK1;
    cur_write = 1'b1;
    if (step_ff == 2'd1) begin
      cur_addr = flash_host_pkg::ADDR_UNLOCK2;
      cur_data = flash_host_pkg::DATA_UNLOCK2;
    end
    case (op_ff)
      flash_host_pkg::OP_READ: begin
        cur_addr = addr_ff;
        cur_write = 1'b0;
      end
      flash_host_pkg::OP_WRITE: begin
        cur_addr = addr_ff;
        cur_data = data_ff;
      end
      flash_host_pkg::OP_QUERY_GENERAL: begin
        cur_addr = flash_host_pkg::ADDR_GEN_QUERY;
        cur_data = flash_host_pkg::CMD_QUERY;
      end
      flash_host_pkg::OP_EXIT_SHORT: begin
        cur_addr = addr_ff;
        cur_data = flash_host_pkg::CMD_EXIT;
      end
      default: begin
        if (step_ff == 2'd2) begin
          cur_addr = flash_host_pkg::ADDR_UNLOCK1;
          case (op_ff)
            flash_host_pkg::OP_QUERY_UNLOCKED: cur_data = flash_host_pkg::CMD_QUERY;
            flash_host_pkg::OP_ID_ENTRY: cur_data = flash_host_pkg::CMD_ID_ENTRY;
            flash_host_pkg::OP_SEC_ENTRY: cur_data = flash_host_pkg::CMD_SEC_ENTRY;
            flash_host_pkg::OP_SEC_PROGRAM: cur_data = flash_host_pkg::CMD_SEC_PROG;
            flash_host_pkg::OP_SEC_LOCK: cur_data = flash_host_pkg::CMD_SEC_LOCK;
            default: cur_data = flash_host_pkg::CMD_EXIT;
          endcase
        end else if (step_ff == 2'd3) begin
          cur_addr = addr_ff;
          cur_data = (op_ff == flash_host_pkg::OP_SEC_LOCK) ? flash_host_pkg::DATA_LOCK_WORD : data_ff;
        end
      end
    endcase
  end

  logic [15:0] rsp_word;
  always_comb begin
    rsp_word = cyc.rdata;
    // lock state lives on bit 3 of word ff in security mode
    if (mode_ff == flash_host_pkg::MODE_SEC && addr_ff == flash_host_pkg::ADDR_LOCK_STATE) begin
      rsp_word = {12'h000, cyc.rdata[flash_host_pkg::LOCK_BIT], 3'h0};
    end
  end

  assign cyc.start = start_ff;
  assign cyc.is_write = cur_write;
  assign cyc.addr = cur_addr;
  assign cyc.wdata = cur_data;
  assign req_ready_out = (state_ff == S_IDLE);
  assign rsp_valid_out = rsp_ff;
  assign rsp_data_out = rdata_ff;
  assign rsp_refused_out = refused_ff;
  assign mode_out = mode_ff;
  assign user_locked_out = locked_ff;
  assign wp_n_out = !protect_boot_in;

  // ************************************************************
  // request sequencing
  // ************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= S_IDLE;
      op_ff <= flash_host_pkg::OP_READ;
      mode_ff <= flash_host_pkg::MODE_ARRAY;
      addr_ff <= 20'h00000;
      data_ff <= 16'h0000;
      step_ff <= 2'd0;
      last_ff <= 2'd0;
      rdata_ff <= 16'h0000;
      rsp_ff <= 1'b0;
      refused_ff <= 1'b0;
      locked_ff <= 1'b0;
      rst_cnt_ff <= 8'h00;
      start_ff <= 1'b0;
      rst_pin_n_out <= 1'b0;
    end else begin
      rsp_ff <= 1'b0;
      refused_ff <= 1'b0;
      start_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          rst_pin_n_out <= 1'b1;
          if (accept) begin
            op_ff <= req_op_in;
            addr_ff <= req_addr_in;
            data_ff <= req_data_in;
            step_ff <= 2'd0;
            last_ff <= last_step;
            if (refuse) begin
              // locked user half or word outside 8..f: never put the program sequence on the pins
              state_ff <= S_DONE;
              refused_ff <= 1'b1;
            end else if (req_op_in == flash_host_pkg::OP_RESET) begin
              state_ff <= S_RESET;
              rst_cnt_ff <= 8'(flash_host_pkg::RESET_CYC - 1);
              rst_pin_n_out <= 1'b0;
            end else begin
              state_ff <= S_ISSUE;
              start_ff <= 1'b1;
            end
          end
        end
        S_ISSUE: begin
          state_ff <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc.done) begin
            if (step_ff == last_ff) begin
              state_ff <= S_DONE;
              rdata_ff <= rsp_word;
              rsp_ff <= 1'b1;
              case (op_ff)
                flash_host_pkg::OP_QUERY_UNLOCKED, flash_host_pkg::OP_QUERY_GENERAL:
                  mode_ff <= flash_host_pkg::MODE_QUERY;
                flash_host_pkg::OP_ID_ENTRY: mode_ff <= flash_host_pkg::MODE_ID;
                flash_host_pkg::OP_SEC_ENTRY: mode_ff <= flash_host_pkg::MODE_SEC;
                flash_host_pkg::OP_EXIT_LONG, flash_host_pkg::OP_EXIT_SHORT:
                  mode_ff <= flash_host_pkg::MODE_ARRAY;
                flash_host_pkg::OP_SEC_LOCK: locked_ff <= 1'b1;
                default: mode_ff <= mode_ff;
              endcase
            end else begin
              step_ff <= step_ff + 2'd1;
              state_ff <= S_ISSUE;
              start_ff <= 1'b1;
            end
          end
        end
        S_RESET: begin
          if (rst_cnt_ff == 8'h00) begin
            rst_pin_n_out <= 1'b1;
            mode_ff <= flash_host_pkg::MODE_ARRAY;
            state_ff <= S_DONE;
            rsp_ff <= 1'b1;
          end else begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
          end
        end
        S_DONE: begin
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  flash_bus_cycle u_cycle (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cyc(cyc.engine),
    .ce_n_out(ce_n_out),
    .oe_n_out(oe_n_out),
    .we_n_out(we_n_out),
    .addr_out(addr_out),
    .dq_out(dq_out),
    .dq_oe_out(dq_oe_out),
    .dq_in(dq_in)
  );

  // ************************************************************
  // checks
  // ************************************************************
  lock_refuse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (accept && req_op_in == flash_host_pkg::OP_SEC_PROGRAM && locked_ff) |=> (refused_ff && state_ff == S_DONE))
    else $error("program of locked user half not refused");
  no_write_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_ff == S_IDLE) |-> we_n_out) else $error("write strobe with no request");
  exit_mode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_ff == S_WAIT && cyc.done && step_ff == last_ff && op_ff == flash_host_pkg::OP_EXIT_SHORT)
    |=> mode_ff == flash_host_pkg::MODE_ARRAY) else $error("exit did not return to array mode");
  query_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (mode_ff == flash_host_pkg::MODE_QUERY && state_ff == S_IDLE && !accept) |=> mode_ff == flash_host_pkg::MODE_QUERY)
    else $error("query mode left without exit");
  reset_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (accept && req_op_in == flash_host_pkg::OP_RESET && !refuse) |=> !rst_pin_n_out [*8])
    else $error("reset pin pulse too short");
  unlock_first_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start_ff && step_ff == 2'd0 && op_ff == flash_host_pkg::OP_ID_ENTRY)
    |-> (cur_addr == flash_host_pkg::ADDR_UNLOCK1 && cur_data == flash_host_pkg::DATA_UNLOCK1))
    else $error("unlock write wrong");
  cmd_query_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start_ff && op_ff == flash_host_pkg::OP_QUERY_UNLOCKED && step_ff == 2'd2) |-> cur_data == flash_host_pkg::CMD_QUERY)
    else $error("query command wrong");
  protect_pin_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    protect_boot_in |-> !wp_n_out) else $error("protect pin not driven low");
endmodule
`default_nettype wire

// ---- flash_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h0000,
  parameter logic [15:0] DEVICE_CODE = 16'h0000
) (
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic rst_n_in,
  input wire logic [19:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_en_out
);
  // ************************************************************
  // command decode, behavioural
  // ************************************************************
  logic [15:0] user_ff [8];
  logic [19:0] lat_a;
  logic [15:0] lat_d;
  logic [7:0] cmd;
  logic pend;
  logic locked;
  logic busy;
  logic arm;
  logic [8:0] ers_unit;
  int step;
  int mode;
  initial begin
    foreach (user_ff[i]) user_ff[i] = 16'hffff;
    locked = 1'b0;
    busy = 1'b0;
    arm = 1'b0;
    ers_unit = 9'h000;
    pend = 1'b0;
    step = 0;
    mode = 0;
  end
  // data latched while the write is open, so host may drop it after
  always @* if (!ce_n_in && !we_n_in && oe_n_in) begin
    lat_a = addr_in;
    lat_d = dq_in;
    pend = 1'b1;
  end
  always @(negedge rst_n_in) begin
    mode = 0;
    step = 0;
  end
  always @(posedge we_n_in or posedge ce_n_in) if (pend) begin
    pend = 1'b0;
    write_word();
  end
  // a program runs a while; exit is ignored until it ends
  always @(posedge busy) #300 busy = 1'b0;
  task write_word;
    logic [14:0] a;
    logic [7:0] d;
    a = lat_a[14:0];
    d = lat_d[7:0];
    if (step == 3) begin
      // bits only ever cleared, never erased
      if (cmd == 8'ha5 && !locked && lat_a[19:3] == 17'h1) begin
        user_ff[lat_a[2:0]] &= lat_d;
        busy = 1'b1;
      end
      if (cmd == 8'h85) locked = 1'b1;
      step = 0;
    end else if (d == 8'hf0 && (step != 2 || a == 15'h5555)) begin
      if (!busy) mode = 0;
      step = 0;
    end else if (step == 2 && arm && (d == 8'h30 || d == 8'h50)) begin
      // unit number only: array contents are not modelled
      ers_unit = (d == 8'h30) ? lat_a[19:11] : {4'h0, lat_a[19:15]};
      arm = 1'b0;
      step = 0;
    end else if (step == 0 && a == 15'h0055 && d == 8'h98) mode = 1;
    else if (step == 0 && a == 15'h5555 && d == 8'haa) step = 1;
    else if (step == 1 && a == 15'h2aaa && d == 8'h55) step = 2;
    else if (step == 2 && a == 15'h5555) begin
      step = 0;
      arm = (d == 8'h80);
      case (d)
        8'h98: mode = 1;
        8'h90: mode = 2;
        8'h88: mode = 3;
        8'ha5, 8'h85: begin
          cmd = d;
          step = 3;
        end
        default: ;
      endcase
    end else begin
      step = 0;
      arm = 1'b0;
    end
  endtask
  assign dq_en_out = !ce_n_in && !oe_n_in && we_n_in && rst_n_in;
  always_comb begin
    case (mode)
      1: dq_out = 16'h5100 | {8'h0, addr_in[7:0]};
      2: dq_out = addr_in[0] ? DEVICE_CODE : MAKER_CODE;
      3: dq_out = addr_in[7:0] == 8'hff ? {12'h0, !locked, 3'h0} :
        addr_in[3] ? user_ff[addr_in[2:0]] : (16'h7e00 | {12'h0, addr_in[3:0]});
      default: dq_out = addr_in[15:0] ^ 16'h3c3c;
    endcase
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [15:0] MAKER = 16'h00c3; // arbitrary
  localparam logic [15:0] DEVID = 16'h5e21; // arbitrary
  logic clk_in, rst_n_in, req_valid_in, protect_boot_in;
  flash_host_pkg::op_t req_op_in;
  logic [19:0] req_addr_in, addr_out;
  logic [15:0] req_data_in, rsp_data_out, dq_out, dev_dq, dq_in, rd;
  logic req_ready_out, rsp_valid_out, rsp_refused_out, user_locked_out, ref_f;
  logic ce_n_out, oe_n_out, we_n_out, rst_pin_n_out, wp_n_out, dq_oe_out, dev_en;
  flash_host_pkg::mode_t mode_out;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  // released bus shows a pattern that flips every half cycle
  assign dq_in = dq_oe_out ? dq_out : dev_en ? dev_dq : (16'ha5c3 ^ {16{clk_in}});
  flash_id_query_modes dut_u (.clk_in, .rst_n_in, .req_valid_in, .req_op_in, .req_addr_in, .req_data_in,
    .req_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_refused_out, .mode_out, .user_locked_out, .ce_n_out,
    .oe_n_out, .we_n_out, .rst_pin_n_out, .wp_n_out, .protect_boot_in, .addr_out, .dq_out, .dq_oe_out, .dq_in);
  flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) dev_u (.ce_n_in(ce_n_out), .oe_n_in(oe_n_out),
    .we_n_in(we_n_out), .rst_n_in(rst_pin_n_out), .addr_in(addr_out), .dq_in(dq_in), .dq_out(dev_dq),
    .dq_en_out(dev_en));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task results;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task req(input flash_host_pkg::op_t op, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      #1 n++;
    end
    req_valid_in = 1'b1;
    req_op_in = op;
    req_addr_in = a;
    req_data_in = d;
    @(posedge clk_in);
    #1 req_valid_in = 1'b0;
    n = 0;
    while (rsp_valid_out !== 1'b1 && rsp_refused_out !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      #1 n++;
    end
    ref_f = rsp_refused_out;
    rd = rsp_data_out;
    if (n == 300) begin
      failures++;
      $display("CHECK FAILED at %0t: no answer", $time);
    end
  endtask
  task rd_chk(input logic [19:0] a, input logic [15:0] exp);
    req(flash_host_pkg::OP_READ, a, 16'h0);
    chk_word(rd, exp);
  endtask
  task mode_chk(input flash_host_pkg::mode_t m);
    chk_word({13'h0, mode_out}, {13'h0, m});
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_array;
    rd_chk(20'h12345, 16'h2345 ^ 16'h3c3c);
    chk_bit(ce_n_out, 1'b1);
    chk_bit(dq_oe_out, 1'b0);
    protect_boot_in = 1'b1;
    @(posedge clk_in);
    #1 chk_bit(wp_n_out, 1'b0);
    protect_boot_in = 1'b0;
    @(posedge clk_in);
    #1 chk_bit(wp_n_out, 1'b1);
  endtask
  task t_query;
    req(flash_host_pkg::OP_QUERY_UNLOCKED, 20'h0, 16'h0);
    mode_chk(flash_host_pkg::MODE_QUERY);
    rd_chk(20'h00010, 16'h5110);
    rd_chk(20'h00011, 16'h5111);
    req(flash_host_pkg::OP_EXIT_SHORT, 20'h3f0a1, 16'h0);
    rd_chk(20'h00010, 16'h0010 ^ 16'h3c3c);
    req(flash_host_pkg::OP_QUERY_GENERAL, 20'h0, 16'h0);
    rd_chk(20'h00027, 16'h5127);
    req(flash_host_pkg::OP_EXIT_LONG, 20'h0, 16'h0);
    mode_chk(flash_host_pkg::MODE_ARRAY);
    rd_chk(20'h00027, 16'h0027 ^ 16'h3c3c);
  endtask
  task t_id;
    req(flash_host_pkg::OP_ID_ENTRY, 20'h0, 16'h0);
    mode_chk(flash_host_pkg::MODE_ID);
    rd_chk(flash_host_pkg::ADDR_MAKER_ID, MAKER);
    rd_chk(flash_host_pkg::ADDR_DEVICE_ID, DEVID);
    req(flash_host_pkg::OP_RESET, 20'h0, 16'h0);
    mode_chk(flash_host_pkg::MODE_ARRAY);
    rd_chk(20'h00001, 16'h0001 ^ 16'h3c3c);
  endtask
  task t_sec;
    req(flash_host_pkg::OP_SEC_ENTRY, 20'h0, 16'h0);
    mode_chk(flash_host_pkg::MODE_SEC);
    rd_chk(flash_host_pkg::ADDR_LOCK_STATE, 16'h0008);
    rd_chk(20'h00003, 16'h7e03);
    req(flash_host_pkg::OP_SEC_PROGRAM, 20'h0000a, 16'hf0f0);
    chk_bit(ref_f, 1'b0);
    req(flash_host_pkg::OP_SEC_PROGRAM, 20'h0000a, 16'h3cff);
    // exit sent while the program still runs must be ignored
    req(flash_host_pkg::OP_EXIT_SHORT, 20'h0, 16'h0);
    rd_chk(20'h0000a, 16'h30f0);
    req(flash_host_pkg::OP_SEC_ENTRY, 20'h0, 16'h0);
    req(flash_host_pkg::OP_SEC_PROGRAM, 20'h00010, 16'h0000);
    chk_bit(ref_f, 1'b1);
    req(flash_host_pkg::OP_SEC_LOCK, flash_host_pkg::ADDR_SEC_USER_LO, 16'h0);
    chk_bit(user_locked_out, 1'b1);
    rd_chk(flash_host_pkg::ADDR_LOCK_STATE, 16'h0000);
    req(flash_host_pkg::OP_SEC_PROGRAM, flash_host_pkg::ADDR_SEC_USER_HI, 16'h0);
    chk_bit(ref_f, 1'b1);
    rd_chk(flash_host_pkg::ADDR_SEC_USER_HI, 16'hffff);
    req(flash_host_pkg::OP_EXIT_LONG, 20'h0, 16'h0);
    mode_chk(flash_host_pkg::MODE_ARRAY);
  endtask
  task erase_seq(input logic [19:0] sa, input logic [15:0] code);
    req(flash_host_pkg::OP_WRITE, flash_host_pkg::ADDR_UNLOCK1, flash_host_pkg::DATA_UNLOCK1);
    req(flash_host_pkg::OP_WRITE, flash_host_pkg::ADDR_UNLOCK2, flash_host_pkg::DATA_UNLOCK2);
    req(flash_host_pkg::OP_WRITE, flash_host_pkg::ADDR_UNLOCK1, 16'h0080);
    req(flash_host_pkg::OP_WRITE, flash_host_pkg::ADDR_UNLOCK1, flash_host_pkg::DATA_UNLOCK1);
    req(flash_host_pkg::OP_WRITE, flash_host_pkg::ADDR_UNLOCK2, flash_host_pkg::DATA_UNLOCK2);
    req(flash_host_pkg::OP_WRITE, sa, code);
  endtask
  task t_erase;
    erase_seq(20'h5a800, 16'h0030);
    chk_word({7'h0, dev_u.ers_unit}, 16'h00b5);
    erase_seq(20'h5a800, 16'h0050);
    chk_word({7'h0, dev_u.ers_unit}, 16'h000b);
    req(flash_host_pkg::OP_SEC_ENTRY, 20'h0, 16'h0);
    rd_chk(20'h0000a, 16'h30f0);
    req(flash_host_pkg::OP_EXIT_SHORT, 20'h0, 16'h0);
    mode_chk(flash_host_pkg::MODE_ARRAY);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      $display("CHECK FAILED at %0t: timeout", $time);
      results();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_op_in = flash_host_pkg::OP_READ;
    req_addr_in = 20'h0;
    req_data_in = 16'h0;
    protect_boot_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    @(posedge clk_in);
    #1;
    t_array();
    t_query();
    t_id();
    t_sec();
    t_erase();
    results();
  end
endmodule
`default_nettype wire
